// file: verif/amcc_props.sv
// Checker: port-level properties of the analog mux control
`timescale 1ns/1ps
`default_nettype none
module amcc_props
    import amcc_pkg::*;
#(
    parameter int CHANNELS = 8
) (
    // Clock, reset and bus
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    // Pins and analog controls
    input wire logic cpu_stop_i,
    input wire logic comparator_raw_i,
    input wire logic sensor_bandgap_enable_o,
    input wire logic [CHANNELS-1:0] channel_select_bits_o,
    input wire logic ground_to_bus_o,
    input wire logic sample_direct_o,
    input wire logic sample_divided_o,
    input wire logic sample_hold_o,
    input wire logic source_illegal_o,
    input wire logic comparator_swap_o,
    input wire logic compare_result_o,
    input wire logic conversion_start_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    // Bus steps reused below
    sequence s_misc_on;
        avs_write_i && avs_address_i == ADDR_MISC && avs_byteenable_i[0]
            && avs_writedata_i[MISC_SENSOR_EN_BIT];
    endsequence
    sequence s_mux1_read;
        avs_read_i && !avs_waitrequest_o && avs_address_i == ADDR_MUX_ONE;
    endsequence
    // Stop must have been low long enough to pass the synchroniser
    a_sensor_on_write: assert property (
        (!cpu_stop_i)[*4] ##0 s_misc_on |=> sensor_bandgap_enable_o)
        else $error("sensor not enabled after write");
    a_stop_forces_off: assert property (
        cpu_stop_i[*4] |-> !sensor_bandgap_enable_o)
        else $error("sensor on during stop");
    a_ground_on_idle: assert property (
        ground_to_bus_o == (channel_select_bits_o == '0))
        else $error("ground route disagrees with channels");
    a_source_decode_ok: assert property (
        source_illegal_o ? sample_hold_o
            : $onehot({sample_direct_o, sample_divided_o, sample_hold_o}))
        else $error("sample source decode broken");
    a_read_wait_once: assert property (
        $rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("read wait not one cycle");
    a_start_one_cycle: assert property (
        conversion_start_o |=> !conversion_start_o)
        else $error("start pulse too long");
    a_mux1_readback: assert property (
        s_mux1_read |-> !avs_readdata_o[MUX1_FLAG_CLR_BIT]
            && avs_readdata_o[MUX1_SWAP_BIT] == comparator_swap_o)
        else $error("mux one readback wrong");
    a_result_pin_polarity: assert property (
        ($stable(comparator_raw_i) && $stable(comparator_swap_o))[*4]
            |-> compare_result_o == (comparator_raw_i ^ comparator_swap_o))
        else $error("result polarity wrong");
endmodule : amcc_props
bind amcc_top amcc_props #(.CHANNELS(CHANNELS)) i_amcc_props (.ref_clk_i,
    .arst_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .cpu_stop_i,
    .comparator_raw_i, .sensor_bandgap_enable_o, .channel_select_bits_o,
    .ground_to_bus_o, .sample_direct_o, .sample_divided_o, .sample_hold_o,
    .source_illegal_o, .comparator_swap_o, .compare_result_o,
    .conversion_start_o);
`default_nettype wire

// file: verif/tb_amcc_top.sv
// Testbench: register, event and comparator checks of the analog mux control
`timescale 1ns/1ps
`default_nettype none
module tb_amcc_top;
    import amcc_pkg::*;
    logic ref_clk_i, arst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o;
    logic [3:0] avs_address_i, avs_byteenable_i;
    logic [31:0] avs_writedata_i, avs_readdata_o;
    logic cpu_wait_i, cpu_stop_i, timer_compare_i, timer_overflow_i;
    logic timer_capture_i, comparator_raw_i, sensor_bandgap_enable_o;
    logic [7:0] channel_select_bits_o;
    logic ground_to_bus_o, sample_direct_o, sample_divided_o, sample_hold_o;
    logic comparator_swap_o, source_illegal_o, conversion_start_o;
    logic conversion_end_o, compare_result_o, irq_o;
    int failures = 0, n_compared = 0, n_start = 0, n_end = 0;
    amcc_top i_amcc_top (.ref_clk_i, .arst_n_i, .avs_address_i, .avs_read_i,
        .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
        .avs_waitrequest_o, .cpu_wait_i, .cpu_stop_i, .timer_compare_i,
        .timer_overflow_i, .timer_capture_i, .comparator_raw_i,
        .sensor_bandgap_enable_o, .channel_select_bits_o, .ground_to_bus_o,
        .sample_direct_o, .sample_divided_o, .sample_hold_o,
        .comparator_swap_o, .source_illegal_o, .conversion_start_o,
        .conversion_end_o, .compare_result_o, .irq_o);
    // 250 MHz clock
    always #2 ref_clk_i = ~ref_clk_i;
    // Count pulses so none is missed while a bus task is busy
    always @(posedge ref_clk_i) begin
        if (conversion_start_o === 1'b1) n_start++;
        if (conversion_end_o === 1'b1) n_end++;
    end
    task wait_clk(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : wait_clk
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task print_verdict;
        if (failures == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict
    // Bus cycles hold until waitrequest is low, then leave one idle edge
    task wr(input logic [3:0] a, input logic [31:0] d);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= 1'b1;
        do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
        avs_write_i <= 1'b0;
        wait_clk(1);
    endtask : wr
    task rd(input logic [3:0] a, output logic [31:0] d);
        avs_address_i <= a;
        avs_read_i <= 1'b1;
        do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
        d = avs_readdata_o;
        avs_read_i <= 1'b0;
        wait_clk(1);
    endtask : rd
    // Timer pin held 3 cycles, then time for the pulse to come out
    task pin(input int w);
        {timer_capture_i, timer_overflow_i, timer_compare_i} <= 3'h1 << w;
        wait_clk(3);
        {timer_capture_i, timer_overflow_i, timer_compare_i} <= 3'h0;
        wait_clk(8);
    endtask : pin
    task t_reset;
        logic [31:0] d;
        rd(ADDR_MISC, d);
        chk("misc", d[0], 0);
        rd(ADDR_MUX_ONE, d);
        chk("mux one", d[7:0], MUX1_RESET);
        rd(ADDR_MUX_TWO, d);
        chk("mux two", d[7:0], MUX2_RESET);
        chk("direct", sample_direct_o, 1);
        chk("ground", ground_to_bus_o, 1);
    endtask : t_reset
    task t_sensor;
        logic [31:0] d;
        wr(ADDR_MISC, 32'h1);
        chk("sensor on", sensor_bandgap_enable_o, 1);
        cpu_wait_i <= 1'b1;
        wait_clk(6);
        chk("sensor wait", sensor_bandgap_enable_o, 1);
        cpu_stop_i <= 1'b1;
        wait_clk(6);
        chk("sensor stop", sensor_bandgap_enable_o, 0);
        rd(ADDR_MISC, d);
        chk("enable bit", d[0], 1);
        rd(ADDR_STATUS, d);
        chk("wait stop", d[9:8], 2'h3);
        cpu_wait_i <= 1'b0;
        cpu_stop_i <= 1'b0;
        wait_clk(6);
        chk("sensor back", sensor_bandgap_enable_o, 1);
        wr(ADDR_MISC, 32'h0);
        chk("sensor off", sensor_bandgap_enable_o, 0);
    endtask : t_sensor
    // Illegal pair must also isolate the capacitor
    task t_source;
        static logic [3:0] exp [4] = '{4'h4, 4'h1, 4'h2, 4'hc};
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_MUX_ONE, i);
            chk("source", {source_illegal_o, sample_hold_o, sample_divided_o,
                sample_direct_o}, exp[i]);
        end
    endtask : t_source
    task t_chan;
        logic [31:0] d;
        wr(ADDR_MUX_ONE, 32'h0);
        wr(ADDR_MUX_TWO, 32'ha5);
        chk("chan", channel_select_bits_o, 8'ha5);
        chk("no ground", ground_to_bus_o, 0);
        rd(ADDR_MUX_TWO, d);
        chk("chan rd", d[7:0], 8'ha5);
        wr(ADDR_MUX_TWO, 32'h0);
        chk("ground", ground_to_bus_o, 1);
    endtask : t_chan
    task t_events;
        logic [31:0] d;
        int s0, e0;
        s0 = n_start;
        e0 = n_end;
        wr(ADDR_MISC, 32'h8000_0200);
        pin(0);
        chk("start cmp", n_start - s0, 1);
        chk("irq set", irq_o, 1);
        rd(ADDR_STATUS, d);
        chk("status", d[EV_START_BIT], 1);
        wait_clk(2);
        chk("irq clr", irq_o, 0);
        rd(ADDR_STATUS, d);
        chk("status clr", d[EV_START_BIT], 0);
        wr(ADDR_MISC, 32'h8000_0000);
        pin(1);
        chk("start ovf", n_start - s0, 2);
        chk("irq masked", irq_o, 0);
        wr(ADDR_MUX_ONE, 32'h11);
        wait_clk(8);
        chk("start sw", n_start - s0, 3);
        pin(2);
        chk("end cap", n_end - e0, 1);
    endtask : t_events
    // Swap change is followed by a separate flag clear, as software should
    task t_cmp;
        logic [31:0] d;
        wr(ADDR_MUX_ONE, 32'h01);
        comparator_raw_i <= 1'b1;
        wait_clk(6);
        chk("result", compare_result_o, 1);
        rd(ADDR_MUX_ONE, d);
        chk("flag", d[MUX1_FLAG_BIT], 1);
        comparator_raw_i <= 1'b0;
        wait_clk(6);
        wr(ADDR_MUX_ONE, 32'h09);
        rd(ADDR_MUX_ONE, d);
        chk("flag clr", d[7:0], 8'h01);
        wr(ADDR_MUX_ONE, 32'h05);
        wait_clk(6);
        wr(ADDR_MUX_ONE, 32'h0d);
        rd(ADDR_MUX_ONE, d);
        chk("flag swap", d[7:0], 8'h05);
        chk("swap", comparator_swap_o, 1);
        chk("result inv", compare_result_o, 1);
        wr(ADDR_MUX_ONE, 32'h29);
        wait_clk(6);
        comparator_raw_i <= 1'b1;
        wait_clk(6);
        chk("cmp irq", irq_o, 1);
        comparator_raw_i <= 1'b0;
        wait_clk(6);
        wr(ADDR_MUX_ONE, 32'h29);
        wait_clk(2);
        chk("cmp irq clr", irq_o, 0);
    endtask : t_cmp
    // Hang guard, well above the expected run
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        failures++;
        print_verdict();
    end
    // Main sequence
    initial begin
        ref_clk_i = 1'b0; arst_n_i = 1'b0;
        {avs_read_i, avs_write_i, cpu_wait_i, cpu_stop_i} = 4'h0;
        {timer_compare_i, timer_overflow_i, timer_capture_i} = 3'h0;
        comparator_raw_i = 1'b0; avs_address_i = 4'h0;
        avs_writedata_i = 32'h0; avs_byteenable_i = 4'hf;
        wait_clk(12);
        arst_n_i <= 1'b1;
        wait_clk(3);
        t_reset(); t_sensor(); t_source(); t_chan(); t_events(); t_cmp();
        print_verdict();
    end
endmodule : tb_amcc_top
`default_nettype wire

// file: verilog/amcc_pkg.sv
// Package: register map, field positions and reset values of the analog mux control
package amcc_pkg;
    // Register byte addresses (word aligned except ADDR_MASK_HI)
    localparam logic [3:0] ADDR_MISC = 4'h0;
    localparam logic [3:0] ADDR_MUX_ONE = 4'h4;
    localparam logic [3:0] ADDR_MUX_TWO = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hc;
    localparam logic [3:0] ADDR_MASK = 4'h0;
    localparam logic [3:0] ADDR_MASK_HI = 4'h1;
    // Misc control register fields
    localparam int MISC_SENSOR_EN_BIT = 0;
    localparam logic [7:0] MISC_RESET = 8'h00;
    // Mux control one fields
    localparam int MUX1_DIRECT_BIT = 0;
    localparam int MUX1_DIVIDED_BIT = 1;
    localparam int MUX1_SWAP_BIT = 2;
    localparam int MUX1_FLAG_CLR_BIT = 3;
    localparam int MUX1_SW_START_BIT = 4;
    localparam int MUX1_CMP_IE_BIT = 5;
    localparam int MUX1_FLAG_BIT = 7;
    localparam logic [7:0] MUX1_RESET = 8'h01;
    // Mux control two: channel selects
    localparam logic [7:0] MUX2_RESET = 8'h00;
    // Event status bits
    localparam int EV_FLAG_BIT = 0;
    localparam int EV_START_BIT = 1;
    localparam int EV_CAPTURE_BIT = 2;
    localparam int EV_WIDTH = 3;
    localparam logic [2:0] EV_RESET = 3'h0;
    // Sample source decode
    typedef enum logic [1:0] {
        AMCC_SRC_HOLD,
        AMCC_SRC_DIVIDED,
        AMCC_SRC_DIRECT,
        AMCC_SRC_ILLEGAL
    } amcc_src_type;
endpackage : amcc_pkg

// file: verilog/amcc_sync.sv
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none
module amcc_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Data
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_r;

    // Second flop alone reads the first
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_r <= '0;
            q_o <= '0;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule : amcc_sync
`default_nettype wire

// file: verilog/amcc_top.sv
// Analog mux and comparator control with Avalon-MM register slave
//
// Our own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module amcc_top
    import amcc_pkg::*;
#(
    parameter int CHANNELS = 8
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    // Avalon-MM slave
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Power modes and timer events (asynchronous levels)
    input wire logic cpu_wait_i,
    input wire logic cpu_stop_i,
    input wire logic timer_compare_i,
    input wire logic timer_overflow_i,
    input wire logic timer_capture_i,
    // Raw analog comparator output (internal node polarity)
    input wire logic comparator_raw_i,
    // Analog controls
    output logic sensor_bandgap_enable_o,
    output logic [CHANNELS-1:0] channel_select_bits_o,
    output logic ground_to_bus_o,
    output logic sample_direct_o,
    output logic sample_divided_o,
    output logic sample_hold_o,
    output logic comparator_swap_o,
    output logic source_illegal_o,
    // Conversion timing
    output logic conversion_start_o,
    output logic conversion_end_o,
    output logic compare_result_o,
    // Interrupt
    output logic irq_o
);
    logic rst_meta_r;
    logic rst_n_r;
    logic [5:0] async_in;
    logic [5:0] sync_q;
    logic wait_s, stop_s, cmp_s, ovf_s, cap_s, raw_s;
    logic cmp_d_r, ovf_d_r, cap_d_r, result_d_r;
    logic sensor_bandgap_enable_r;
    logic [7:0] mux_one_r;
    logic [CHANNELS-1:0] channel_select_bits_r;
    logic compare_flag_r;
    logic [EV_WIDTH-1:0] status_r;
    logic [EV_WIDTH-1:0] mask_r;
    logic [EV_WIDTH-1:0] events;
    logic result;
    logic start_ev, end_ev, flag_set, flag_clr;
    logic wr, rd, rd_done_r;
    logic [31:0] rdata;
    amcc_src_type src;

    // Byte address to register index, word aligned
    function automatic logic hit(input logic [3:0] a, input logic [3:0] ref_a);
        hit = (a[3:2] == ref_a[3:2]);
    endfunction : hit

    // Reset release through two flops
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // Pins cross into the clock domain before use
    assign async_in = {comparator_raw_i, timer_capture_i, timer_overflow_i,
                       timer_compare_i, cpu_stop_i, cpu_wait_i};

    amcc_sync #(
        .WIDTH(6)
    ) u_sync (
        .clk_i(ref_clk_i),
        .rst_n_i(rst_n_r),
        .d_i(async_in),
        .q_o(sync_q)
    );

    assign wait_s = sync_q[0];
    assign stop_s = sync_q[1];
    assign cmp_s = sync_q[2];
    assign ovf_s = sync_q[3];
    assign cap_s = sync_q[4];
    assign raw_s = sync_q[5];

    // Edge history of synchronised levels
    always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cmp_d_r <= 1'b0;
            ovf_d_r <= 1'b0;
            cap_d_r <= 1'b0;
            result_d_r <= 1'b0;
        end else begin
            cmp_d_r <= cmp_s;
            ovf_d_r <= ovf_s;
            cap_d_r <= cap_s;
            result_d_r <= result;
        end
    end

    // Bus strobes: one wait state on reads so data comes from a flop
    assign wr = avs_write_i && avs_byteenable_i[0];
    assign rd = avs_read_i && !rd_done_r;
    assign avs_waitrequest_o = rd;

    always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rd_done_r <= 1'b0;
        end else begin
            rd_done_r <= rd;
        end
    end

    // Misc control register: sensor enable
    always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            sensor_bandgap_enable_r <= MISC_RESET[MISC_SENSOR_EN_BIT];
        end else if (wr && hit(avs_address_i, ADDR_MISC)) begin
            sensor_bandgap_enable_r <= avs_writedata_i[MISC_SENSOR_EN_BIT];
        end
    end

    // Stop forces the sensor off; wait leaves it alone
    assign sensor_bandgap_enable_o = sensor_bandgap_enable_r && !stop_s;
    // wait_s deliberately not gating the enable

    // Mux control one: source bits, swap, software start, irq enable
    always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            mux_one_r <= MUX1_RESET;
        end else if (wr && hit(avs_address_i, ADDR_MUX_ONE)) begin
            mux_one_r <= avs_writedata_i[7:0];
            mux_one_r[MUX1_FLAG_CLR_BIT] <= 1'b0;
            mux_one_r[MUX1_FLAG_BIT] <= 1'b0;
        end else begin
            // Software start is a one-shot
            mux_one_r[MUX1_SW_START_BIT] <= 1'b0;
        end
    end

    // Mux control two: independent channel selects
    always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            channel_select_bits_r <= MUX2_RESET[CHANNELS-1:0];
        end else if (wr && hit(avs_address_i, ADDR_MUX_TWO)) begin
            channel_select_bits_r <= avs_writedata_i[CHANNELS-1:0];
        end
    end

    assign channel_select_bits_o = channel_select_bits_r;
    // Nothing selected discharges the bus to ground
    assign ground_to_bus_o = (channel_select_bits_r == '0);

    // Source decode; illegal combination isolates the capacitor too
    assign src = amcc_src_type'({mux_one_r[MUX1_DIRECT_BIT],
                                 mux_one_r[MUX1_DIVIDED_BIT]});
    always_comb begin
        sample_direct_o = 1'b0;
        sample_divided_o = 1'b0;
        sample_hold_o = 1'b0;
        source_illegal_o = 1'b0;
        case (src)
            AMCC_SRC_HOLD: sample_hold_o = 1'b1;
            AMCC_SRC_DIVIDED: sample_divided_o = 1'b1;
            AMCC_SRC_DIRECT: sample_direct_o = 1'b1;
            default: begin
                sample_hold_o = 1'b1;
                source_illegal_o = 1'b1;
            end
        endcase
    end
    // Channel changes under a live source are software's concern

    // Swap inverts internal output, so pin polarity is unchanged
    assign comparator_swap_o = mux_one_r[MUX1_SWAP_BIT];
    assign result = raw_s ^ mux_one_r[MUX1_SWAP_BIT];
    assign compare_result_o = result_d_r;

    // Conversion start: compare, overflow or software
    assign start_ev = (cmp_s && !cmp_d_r) || (ovf_s && !ovf_d_r)
                      || mux_one_r[MUX1_SW_START_BIT];
    // Conversion end: capture or comparator rise
    assign flag_set = result && !result_d_r;
    assign end_ev = (cap_s && !cap_d_r) || flag_set;

    // Timing strobes registered
    always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            conversion_start_o <= 1'b0;
            conversion_end_o <= 1'b0;
        end else begin
            conversion_start_o <= start_ev;
            conversion_end_o <= end_ev;
        end
    end

    // Compare flag; a new rise wins over the clear
    assign flag_clr = wr && hit(avs_address_i, ADDR_MUX_ONE)
                      && avs_writedata_i[MUX1_FLAG_CLR_BIT];
    always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            compare_flag_r <= 1'b0;
        end else if (flag_set) begin
            compare_flag_r <= 1'b1;
        end else if (flag_clr) begin
            compare_flag_r <= 1'b0;
        end
    end

    // Sticky event status, cleared by a status read; set wins
    assign events = {cap_s && !cap_d_r, start_ev, flag_set};
    // Only the bits the read returned are cleared, so an event landing in
    // the wait state between capture and accept is not lost
    always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            status_r <= EV_RESET;
        end else if (rd_done_r && hit(avs_address_i, ADDR_STATUS)) begin
            status_r <= (status_r & ~avs_readdata_o[EV_WIDTH-1:0]) | events;
        end else begin
            status_r <= status_r | events;
        end
    end

    // Interrupt mask shares the misc word; bit 31 guards it from enable writes
    always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            mask_r <= EV_RESET;
        end else if (wr && hit(avs_address_i, ADDR_MASK)
                     && avs_writedata_i[31]) begin
            mask_r <= avs_writedata_i[EV_WIDTH-1+8:8];
        end
    end

    // Level interrupt; comparator source also gated by its own enable
    assign irq_o = |(status_r & mask_r) ||
                   (compare_flag_r && mux_one_r[MUX1_CMP_IE_BIT]);

    // Read mux; reserved bits zero except mux one bit 6, clear bit reads zero
    always_comb begin
        rdata = 32'h0000_0000;
        if (hit(avs_address_i, ADDR_MISC)) begin
            rdata[MISC_SENSOR_EN_BIT] = sensor_bandgap_enable_r;
            rdata[EV_WIDTH-1+8:8] = mask_r;
        end else if (hit(avs_address_i, ADDR_MUX_ONE)) begin
            rdata[7:0] = mux_one_r;
            rdata[MUX1_FLAG_CLR_BIT] = 1'b0;
            rdata[MUX1_FLAG_BIT] = compare_flag_r;
        end else if (hit(avs_address_i, ADDR_MUX_TWO)) begin
            rdata[CHANNELS-1:0] = channel_select_bits_r;
        end else begin
            rdata[EV_WIDTH-1:0] = status_r;
            rdata[8] = wait_s;
            rdata[9] = stop_s;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (rd) begin
            avs_readdata_o <= rdata;
        end
    end
endmodule : amcc_top
`default_nettype wire
